// ===== sar_conv_pkg.sv
// Purpose: Shared constants and types for the SAR converter control block.
// Assumes: The core clock ref_clk runs at 100 MHz.
// Notes:   Timing figures are kept in ns and turned into cycle counts here.

package sar_conv_pkg;

  // ---------------------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------------------
  localparam int RESULT_W_DEF = 18;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_MIN_NS = 500;
  localparam int CONV_MAX_NS = 700;
  // A least time rounds up, a longest time rounds down.
  localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int CONV_RANGE_CYC = CONV_MAX_CYC - CONV_MIN_CYC;
  localparam int SAR_STEP_CYC = 2;
  localparam int CONV_CNT_W = 8;

  // ---------------------------------------------------------------------------
  // Scrambler reset value and taps
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum {PHASE_ACQ, PHASE_CONV} phase_e;
  typedef enum {MODE_CS, MODE_CHAIN} if_mode_e;

  typedef struct packed {
    logic conversion_start_select;
    logic chain_in;
    logic serial_clock;
  } host_pins_s;

  typedef struct packed {
    logic data;
    logic oe;
  } dout_pin_s;

  typedef struct packed {
    logic inputs_connected;
    logic powered_down;
    logic converting;
  } front_end_s;

endpackage : sar_conv_pkg

// ===== sar_conv_ctrl.sv
// Purpose: Conversion and serial interface control of an 18-bit SAR converter.
// Assumes: Host pins are asynchronous to ref_clk; analog levels arrive as
//          unsigned digitised codes on positive/negative_analog_input.
// Notes:   One clock domain; every host pin is seen through a two-stage synchroniser.

`timescale 1ns/100ps

module sar_conv_ctrl
  import sar_conv_pkg::*;
#(
  parameter int RESULT_W = RESULT_W_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire host_pins_s host_pins,
  input wire logic [RESULT_W-1:0] positive_analog_input,
  input wire logic [RESULT_W-1:0] negative_analog_input,
  output dout_pin_s dout_pin,
  output front_end_s front_end,
  output logic [RESULT_W-1:0] result_code
);

  localparam int FRAME_W = RESULT_W + 1;
  localparam int LEFT_W = $clog2(FRAME_W + 1);
  localparam int STEP_W = $clog2(SAR_STEP_CYC + 1);

  // ---------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------------------
  // Every pin edge is seen two to three cycles late, so the serial clock must stay
  // well below a quarter of ref_clk; the data pin then lags each fall by as much.
  host_pins_s pins_meta_r;
  host_pins_s pins_sync_r;
  host_pins_s pins_prev_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pins_meta_r <= '0;
      pins_sync_r <= '0;
      pins_prev_r <= '0;
    end else begin
      pins_meta_r <= host_pins;
      pins_sync_r <= pins_meta_r;
      pins_prev_r <= pins_sync_r;
    end
  end

  logic start_rise;
  logic sclk_fall;
  logic cnv_s;
  logic din_s;
  assign cnv_s = pins_sync_r.conversion_start_select;
  assign din_s = pins_sync_r.chain_in;
  assign start_rise = cnv_s & ~pins_prev_r.conversion_start_select;
  // The serial clock is only watched for shifting, never for conversion timing.
  assign sclk_fall = ~pins_sync_r.serial_clock & pins_prev_r.serial_clock;

  // ---------------------------------------------------------------------------
  // Conversion timing
  // ---------------------------------------------------------------------------
  phase_e phase_r;
  logic [7:0] lfsr_r;
  logic [CONV_CNT_W-1:0] conv_cnt_r;
  logic [CONV_CNT_W-1:0] conv_len_r;
  logic [CONV_CNT_W-1:0] conv_len_nxt;
  logic [4:0] extra;
  logic conv_done_r;

  // Free-running scrambler gives each conversion its own length. Values above
  // the range are clipped to the longest, so that end is favoured; a fair
  // spread would have cost a divider.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_r <= LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[6:0], ^(lfsr_r & LFSR_TAPS)};
    end
  end

  assign extra = (lfsr_r[4:0] > 5'(CONV_RANGE_CYC)) ? 5'(CONV_RANGE_CYC) : lfsr_r[4:0];
  assign conv_len_nxt = CONV_CNT_W'(CONV_MIN_CYC) + {3'h0, extra};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= PHASE_ACQ;
      conv_cnt_r <= '0;
      conv_len_r <= '0;
      conv_done_r <= 1'b0;
    end else begin
      conv_done_r <= 1'b0;
      unique case (phase_r)
        PHASE_ACQ: begin
          if (start_rise) begin
            phase_r <= PHASE_CONV;
            conv_cnt_r <= '0;
            conv_len_r <= conv_len_nxt;
          end
        end
        PHASE_CONV: begin
          // Counted on ref_clk, which plays the part of the internal oscillator.
          conv_cnt_r <= conv_cnt_r + CONV_CNT_W'(1);
          if (conv_cnt_r == conv_len_r - CONV_CNT_W'(1)) begin
            phase_r <= PHASE_ACQ;
            conv_done_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Sampling and successive approximation
  // ---------------------------------------------------------------------------
  logic signed [RESULT_W:0] diff;
  logic [RESULT_W-1:0] sign_bit;
  logic [RESULT_W-1:0] target_r;
  logic [RESULT_W-1:0] sar_acc_r;
  logic [RESULT_W-1:0] sar_bit_r;
  logic [RESULT_W-1:0] trial;
  logic [STEP_W-1:0] step_cnt_r;

  assign diff = $signed({1'b0, positive_analog_input}) - $signed({1'b0, negative_analog_input});
  assign sign_bit = {1'b1, {(RESULT_W - 1){1'b0}}};
  assign trial = sar_acc_r | sar_bit_r;

  // Full scale spans twice the reference, so the halved difference fits 18 bits.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      target_r <= '0;
      sar_acc_r <= '0;
      sar_bit_r <= '0;
      step_cnt_r <= '0;
    end else if (phase_r == PHASE_ACQ && start_rise) begin
      target_r <= diff[RESULT_W:1] ^ sign_bit;
      sar_acc_r <= '0;
      sar_bit_r <= sign_bit;
      step_cnt_r <= '0;
    end else if (phase_r == PHASE_CONV && sar_bit_r != '0) begin
      // Each trial is given SAR_STEP_CYC cycles to settle before it is judged.
      if (step_cnt_r == STEP_W'(SAR_STEP_CYC - 1)) begin
        step_cnt_r <= '0;
        if (trial <= target_r) begin
          sar_acc_r <= trial;
        end
        sar_bit_r <= sar_bit_r >> 1;
      end else begin
        step_cnt_r <= step_cnt_r + STEP_W'(1);
      end
    end
  end

  // The trial search finishes well inside the shortest conversion.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      result_code <= '0;
    end else if (phase_r == PHASE_CONV && conv_cnt_r == conv_len_r - CONV_CNT_W'(1)) begin
      result_code <= sar_acc_r ^ sign_bit;
    end
  end

  // ---------------------------------------------------------------------------
  // Front-end switch and power state
  // ---------------------------------------------------------------------------
  // Switch and power move together: the converter only draws power while its
  // capacitors are cut off from the pins.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      front_end <= '{inputs_connected: 1'b1, powered_down: 1'b1, converting: 1'b0};
    end else if (phase_r == PHASE_ACQ && start_rise) begin
      front_end <= '{inputs_connected: 1'b0, powered_down: 1'b0, converting: 1'b1};
    end else if (phase_r == PHASE_CONV && conv_cnt_r == conv_len_r - CONV_CNT_W'(1)) begin
      front_end <= '{inputs_connected: 1'b1, powered_down: 1'b1, converting: 1'b0};
    end
  end

  // ---------------------------------------------------------------------------
  // Mode selection and serial output
  // ---------------------------------------------------------------------------
  if_mode_e mode_r;
  logic selected;
  logic sel_prev_r;
  logic sel_fall;
  logic armed_r;
  logic spare_r;
  logic [LEFT_W-1:0] left_r;
  logic [FRAME_W-1:0] out_sr_r;

  // In 3-wire use the chain input is tied high and the start pin selects; in
  // 4-wire use the start pin stays high and the chain input selects alone.
  always_comb begin
    if (mode_r == MODE_CS) begin
      selected = ~(cnv_s & din_s);
    end else begin
      selected = ~cnv_s;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_prev_r <= 1'b0;
    end else begin
      sel_prev_r <= selected;
    end
  end

  assign sel_fall = selected & ~sel_prev_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= MODE_CS;
    end else if (phase_r == PHASE_ACQ && start_rise) begin
      mode_r <= din_s ? MODE_CS : MODE_CHAIN;
    end
  end

  // A frame that opens on select keeps a spare bit at the bottom of the shifter.
  // Chain bits from upstream must enter above it, or a stray zero would sit
  // between this device's last bit and the upstream device's first.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      spare_r <= 1'b0;
    end else if (conv_done_r && !start_rise) begin
      spare_r <= ~selected;
    end
  end

  // Armed means a result waits for the select edge; a new start drops it.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_r <= 1'b0;
    end else if (start_rise) begin
      armed_r <= 1'b0;
    end else if (conv_done_r) begin
      armed_r <= ~selected;
    end else if (sel_fall) begin
      armed_r <= 1'b0;
    end
  end

  // Data only leaves during acquisition; a read during conversion sees a
  // tristated pin, which is why the host must wait for the result.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dout_pin <= '{data: 1'b0, oe: 1'b0};
      left_r <= '0;
      out_sr_r <= '0;
    end else if (start_rise) begin
      // A refused start edge inside a conversion still releases the pin.
      dout_pin.oe <= 1'b0;
    end else if (conv_done_r) begin
      if (selected) begin
        // Selected at the end of conversion asks for the busy slot.
        out_sr_r <= {1'b0, result_code};
        dout_pin <= '{data: 1'b0, oe: 1'b1};
        left_r <= LEFT_W'(FRAME_W);
      end else begin
        out_sr_r <= {result_code, 1'b0};
        left_r <= LEFT_W'(RESULT_W);
      end
    end else if (armed_r && sel_fall) begin
      dout_pin <= '{data: out_sr_r[FRAME_W-1], oe: 1'b1};
    end else if (dout_pin.oe && !selected) begin
      dout_pin.oe <= 1'b0;
    end else if (dout_pin.oe && sclk_fall) begin
      // In the chain the upstream bit enters behind the outgoing one.
      if (mode_r == MODE_CHAIN && spare_r) begin
        out_sr_r <= {out_sr_r[FRAME_W-2:1], din_s, 1'b0};
      end else if (mode_r == MODE_CHAIN) begin
        out_sr_r <= {out_sr_r[FRAME_W-2:0], din_s};
      end else begin
        out_sr_r <= {out_sr_r[FRAME_W-2:0], 1'b0};
      end
      dout_pin.data <= out_sr_r[FRAME_W-2];
      if (mode_r == MODE_CS) begin
        left_r <= left_r - LEFT_W'(1);
        if (left_r == LEFT_W'(1)) begin
          dout_pin.oe <= 1'b0;
        end
      end
    end
  end

endmodule : sar_conv_ctrl

// ===== sar_host_model.sv
// Purpose: Host model that drives the start, chain and serial clock pins.
// Assumes: Its tasks are called from the bench at ref_clk falling edges.
// Notes: The serial clock idles high and toggles only inside a frame.
//        A released data pin reads high, as through its pull-up.
`timescale 1ns/100ps
module sar_host_model
  import sar_conv_pkg::*;
(
  input wire logic ref_clk,
  input wire dout_pin_s dout_pin,
  output host_pins_s host_pins
);
  initial host_pins = 3'h3;

  task automatic pins(input logic s, input logic c);
    @(negedge ref_clk);
    host_pins.conversion_start_select = s;
    host_pins.chain_in = c;
  endtask : pins

  // Called only once a conversion has ended, so the clock never paces one.
  task automatic frame(input int nf, output logic [18:0] b);
    b = 19'h0;
    for (int k = 0; k < nf; k++) begin
      b = {b[17:0], dout_pin.oe ? dout_pin.data : 1'b1};
      host_pins.serial_clock = 1'b0;
      #40;
      host_pins.serial_clock = 1'b1;
      #40;
    end
  endtask : frame
endmodule : sar_host_model

// ===== sar_conv_ctrl_checker.sv
// Purpose: Port-level checks of conversion timing and the output pin.
// Assumes: One clock domain, ref_clk, with resetn.
// Notes: Serial clock falls are counted raw, so counts allow sync lag.
`timescale 1ns/100ps
module sar_conv_ctrl_checker
  import sar_conv_pkg::*;
#(
  parameter int RESULT_W = RESULT_W_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire host_pins_s host_pins,
  input wire dout_pin_s dout_pin,
  input wire front_end_s front_end,
  input wire logic [RESULT_W-1:0] result_code
);
  logic [7:0] conv_cnt_r;
  logic [4:0] fall_cnt_r;
  logic sclk_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) conv_cnt_r <= 8'h00;
    else conv_cnt_r <= front_end.converting ? conv_cnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) sclk_r <= 1'h1;
    else sclk_r <= host_pins.serial_clock;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) fall_cnt_r <= 5'h00;
    else if (!dout_pin.oe) fall_cnt_r <= 5'h00;
    else if (sclk_r && !host_pins.serial_clock) fall_cnt_r <= fall_cnt_r + 5'h01;
  end

  property p_len;
    $fell(front_end.converting)
      |-> conv_cnt_r >= 8'(CONV_MIN_CYC) && conv_cnt_r <= 8'(CONV_MAX_CYC);
  endproperty
  a_len: assert property (p_len) else $error("conversion length out of bounds");
  property p_iso;
    front_end.converting |-> !front_end.inputs_connected && !front_end.powered_down;
  endproperty
  a_iso: assert property (p_iso) else $error("inputs connected in conversion");
  property p_acq;
    !front_end.converting |-> front_end.inputs_connected && front_end.powered_down;
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition not powered down");
  property p_hiz;
    $rose(front_end.converting) |-> !dout_pin.oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven at start");
  property p_res;
    !$fell(front_end.converting) |-> $stable(result_code);
  endproperty
  a_res: assert property (p_res) else $error("result moved outside end");
  property p_oe;
    dout_pin.oe |-> !front_end.converting;
  endproperty
  a_oe: assert property (p_oe) else $error("output driven in conversion");
  property p_start;
    $rose(host_pins.conversion_start_select) && !front_end.converting
      |-> ##[1:4] front_end.converting;
  endproperty
  a_start: assert property (p_start) else $error("start edge not taken");
  property p_falls;
    dout_pin.oe |-> fall_cnt_r <= 5'h13;
  endproperty
  a_falls: assert property (p_falls) else $error("output held too long");
endmodule : sar_conv_ctrl_checker

bind sar_conv_ctrl sar_conv_ctrl_checker #(.RESULT_W(RESULT_W)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .host_pins(host_pins),
  .dout_pin(dout_pin), .front_end(front_end), .result_code(result_code));

// ===== tb_sar_conv_ctrl.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: The host model drives pins; the bench drives analog codes.
// Notes: Each test task runs one interface option end to end.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t got %0h exp %0h", $time, g, e); end end
module tb_sar_conv_ctrl;
  import sar_conv_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [17:0] p_in = 18'h0;
  logic [17:0] n_in = 18'h0;
  logic [17:0] e;
  logic [18:0] got;
  host_pins_s host_pins;
  dout_pin_s dout_pin;
  front_end_s front_end;
  logic [17:0] result_code;
  int err_count = 0;
  int checks_done = 0;
  initial forever #5 ref_clk = ~ref_clk;
  sar_conv_ctrl DUT (.ref_clk(ref_clk), .resetn(resetn), .host_pins(host_pins),
    .positive_analog_input(p_in), .negative_analog_input(n_in),
    .dout_pin(dout_pin), .front_end(front_end), .result_code(result_code));
  sar_host_model host (.ref_clk(ref_clk), .dout_pin(dout_pin), .host_pins(host_pins));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic wait_conv(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && front_end.converting !== v; i++) @(negedge ref_clk);
    if (i == lim) begin
      err_count++;
      end_sim();
    end
  endtask : wait_conv

  // A low start pin during conversion asks for the busy bit.
  task automatic convert(input logic [17:0] p, input logic [17:0] n, input logic c,
                         input logic busy);
    logic [18:0] d;
    d = {1'b0, p} - {1'b0, n};
    e = d[18:1];
    p_in = p;
    n_in = n;
    host.pins(1'b1, c);
    wait_conv(1'b1, 10);
    `CHK(dout_pin.oe, 1'b0)
    `CHK({front_end.inputs_connected, front_end.powered_down}, 2'h0)
    if (busy) host.pins(1'b0, c);
    wait_conv(1'b0, 100);
    `CHK(result_code, e)
    `CHK({front_end.inputs_connected, front_end.powered_down}, 2'h3)
    repeat (3) @(negedge ref_clk);
  endtask : convert

  task automatic t_cs3;
    convert(18'h2A5C3, 18'h0F00F, 1'b1, 1'b0);
    `CHK(dout_pin.oe, 1'b0)
    host.pins(1'b0, 1'b1);
    repeat (5) @(negedge ref_clk);
    host.frame(18, got);
    `CHK(got[17:0], e)
    `CHK(dout_pin.oe, 1'b0)
    $display("test cs3 done");
  endtask : t_cs3

  task automatic t_cs3_busy;
    convert(18'h00010, 18'h30000, 1'b1, 1'b1);
    `CHK({dout_pin.oe, dout_pin.data}, 2'h2)
    host.frame(19, got);
    `CHK(got, {1'b0, e})
    `CHK(dout_pin.oe, 1'b0)
    $display("test cs3 busy done");
  endtask : t_cs3_busy

  task automatic t_cs4;
    convert(18'h3FFFF, 18'h00000, 1'b1, 1'b0);
    host.pins(1'b1, 1'b0);
    repeat (5) @(negedge ref_clk);
    host.frame(6, got);
    `CHK(got[5:0], e[17:12])
    host.pins(1'b1, 1'b1);
    repeat (5) @(negedge ref_clk);
    `CHK(dout_pin.oe, 1'b0)
    $display("test cs4 done");
  endtask : t_cs4

  task automatic t_chain;
    host.pins(1'b0, 1'b0);
    repeat (5) @(negedge ref_clk);
    convert(18'h12345, 18'h23456, 1'b0, 1'b0);
    host.pins(1'b1, 1'b1);
    host.pins(1'b0, 1'b1);
    repeat (5) @(negedge ref_clk);
    host.frame(19, got);
    `CHK(got, {e, 1'b1})
    host.pins(1'b1, 1'b1);
    repeat (5) @(negedge ref_clk);
    `CHK({dout_pin.oe, front_end.converting}, 2'h1)
    $display("test chain done");
  endtask : t_chain

  initial begin
    repeat (5) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (5) @(negedge ref_clk);
    t_cs3();
    t_cs3_busy();
    t_cs4();
    t_chain();
    end_sim();
  end

  initial begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule : tb_sar_conv_ctrl
